/* logic/usb_ep_defines.vh */
// Constants for the endpoint index, clock recovery and endpoint FIFO block.
// Assumes indirect register addresses of 6 bits and byte-wide data.
`ifndef USB_EP_DEFINES_VH
`define USB_EP_DEFINES_VH

// ----------------------------------------------------------------------
// Indirect register addresses
// ----------------------------------------------------------------------
`define ADDR_ENDPOINT_INDEX_SELECT 6'h0e
`define ADDR_CLOCK_RECOVERY_CONTROL 6'h0f
`define ADDR_IN_ENDPOINT_CONTROL_HIGH 6'h12
`define ADDR_FIFO_PORT_FIRST 6'h20
`define ADDR_FIFO_PORT_LAST 6'h23

// ----------------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------------
`define ENDPOINT_INDEX_RESET 4'h0
`define CLOCK_RECOVERY_RESET 8'h09
`define NUM_ENDPOINTS 4'h4
`define BIT_RECOVERY_ENABLE 7
`define BIT_RECOVERY_SINGLE_STEP 6
`define BIT_LOW_SPEED_RECOVERY 5
`define BIT_DOUBLE_IN 7
`define BIT_DOUBLE_OUT 6
`define BIT_DIRECTION_SELECT 3
`define BIT_SPLIT 2

// ----------------------------------------------------------------------
// FIFO memory layout, offsets inside the 1024-byte space
// ----------------------------------------------------------------------
`define FIFO_BYTES 1024
`define EP0_BASE 10'h000
`define EP3_BASE 10'h040
`define EP2_BASE 10'h240
`define EP1_BASE 10'h340
`define EP0_SIZE 11'h040
`define EP1_SIZE 11'h080
`define EP2_SIZE 11'h100
`define EP3_SIZE 11'h200

// ----------------------------------------------------------------------
// Clock recovery timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_PS 4000
`define FRAME_TIME_US 1000
`define TRIM_RESET 7'h40
`define COARSE_STEP 7'h04

`endif

/* logic/endpoint_fifo_ptr.v */
// Pointer and occupancy tracking for one logical FIFO inside the endpoint
// memory. Assumes the caller only pushes when not full, pops when not empty.
`timescale 1ns/1ps
`default_nettype none

module endpoint_fifo_ptr
(
  input wire clk_i,
  input wire srst_i,
  input wire [10:0] size_i,
  input wire push_i,
  input wire pop_i,
  output reg [9:0] wr_ptr_o,
  output reg [9:0] rd_ptr_o,
  output reg [10:0] count_o
);

  wire [10:0] wr_next;
  wire [10:0] rd_next;

  // Pointers wrap at the current region size, which changes with split mode
  assign wr_next = {1'b0, wr_ptr_o} + 11'h001;
  assign rd_next = {1'b0, rd_ptr_o} + 11'h001;

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wr_ptr_o <= 10'h000;
      rd_ptr_o <= 10'h000;
      count_o <= 11'h000;
    end
    else
    begin
      if (push_i)
      begin
        wr_ptr_o <= (wr_next >= size_i) ? 10'h000 : wr_next[9:0];
      end
      if (pop_i)
      begin
        rd_ptr_o <= (rd_next >= size_i) ? 10'h000 : rd_next[9:0];
      end
      if (push_i && !pop_i)
      begin
        count_o <= count_o + 11'h001;
      end
      else if (pop_i && !push_i)
      begin
        count_o <= count_o - 11'h001;
      end
    end
  end

endmodule // endpoint_fifo_ptr

`default_nettype wire

/* logic/usb_endpoint_fifo_and_clock_recovery.v */
// Endpoint index, clock recovery control and 1024-byte endpoint FIFO memory
// of a full/low speed USB function. Assumes a byte-wide indirect register
// port driven by the CPU side and a packet engine on the USB side, all on
// clk_i; the USB clock itself is supplied by the system.
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep_defines.vh"

// Behaviour
// RULE1 - Index low nibble selects endpoint 0 to 3; 4 to 15 are reserved.
// RULE2 - Index upper nibble reads zero and ignores writes.
// RULE3 - System supplies a 6 MHz USB clock in low speed operation.
// RULE4 - System supplies a 48 MHz USB clock in full speed operation.
// RULE5 - When enabled, recovery trims the oscillator from received frame timing.
// RULE6 - Software sets low-speed recovery bit when recovering at low speed.
// RULE7 - Control bit 7 enables clock recovery.
// RULE8 - Control bit 6 forces single-step calibration.
// RULE9 - Bit 5 picks low-speed recovery; low bits written as 1001b.
// RULE10 - 1024 bytes of memory hold FIFOs for endpoints 0 to 3.
// RULE11 - Endpoints 1 to 3 FIFOs serve IN, OUT or both.
// RULE12 - Split mode: upper half IN, lower half OUT.
// RULE13 - Unsplit: one FIFO, direction from direction select bit.
// RULE14 - Double buffering halves max packet, holds two packets; endpoints 1-3.
// RULE15 - Split: double buffering per half; unsplit: whole FIFO.
// RULE16 - Max packet sizes per endpoint, split and double buffer settings.
// RULE17 - Port read removes one byte; port write appends one byte.
// RULE18 - Split endpoint: port reads take OUT bytes, writes feed IN.
// RULE19 - Software writes index before touching endpoint control registers.
// RULE20 - FIFO ports sit at indirect addresses 0x20 to 0x23.
// RULE21 - Reserved endpoint select: indexed writes ignored, reads return zero.
module usb_endpoint_fifo_and_clock_recovery
#(
  parameter FRAME_CYCLES = (`FRAME_TIME_US * 1000000) / `CLK_PERIOD_PS
)
(
  input wire clk_i,
  input wire srst_i,
  input wire [5:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  input wire [1:0] usb_ep_i,
  input wire usb_push_i,
  input wire [7:0] usb_push_data_i,
  input wire usb_pop_i,
  output reg [7:0] usb_pop_data_o,
  output reg [9:0] max_in_packet_o,
  output reg [9:0] max_out_packet_o,
  input wire sof_i,
  input wire keepalive_i,
  output reg [6:0] osc_trim_o
);

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  reg [3:0] endpoint_select_q;
  reg [7:0] clock_recovery_q;
  reg [3:0] split_q;
  reg [3:0] double_in_q;
  reg [3:0] double_out_q;
  reg [3:0] direction_select_q;
  reg [7:0] mem [0:`FIFO_BYTES-1];
  wire index_valid;
  wire [1:0] idx_ep;
  wire idx_write;
  wire fifo_port_hit;
  wire [1:0] port_ep;
  assign index_valid = (endpoint_select_q < `NUM_ENDPOINTS); // [RULE1]
  assign idx_ep = endpoint_select_q[1:0];
  assign idx_write = reg_wr_i && index_valid; // [RULE21]
  assign fifo_port_hit = (reg_addr_i >= `ADDR_FIFO_PORT_FIRST) &&
                         (reg_addr_i <= `ADDR_FIFO_PORT_LAST); // [RULE20]
  assign port_ep = reg_addr_i[1:0];

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      endpoint_select_q <= `ENDPOINT_INDEX_RESET;
      clock_recovery_q <= `CLOCK_RECOVERY_RESET;
      split_q <= 4'h0;
      double_in_q <= 4'h0;
      double_out_q <= 4'h0;
      direction_select_q <= 4'h0;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == `ADDR_ENDPOINT_INDEX_SELECT)
        endpoint_select_q <= reg_wdata_i[3:0]; // [RULE2]
      // Low bits kept as written; software owns their value
      if (reg_addr_i == `ADDR_CLOCK_RECOVERY_CONTROL)
        clock_recovery_q <= reg_wdata_i; // [RULE9]
      // Endpoint 0 has a fixed single FIFO, so its config stays zero
      if (idx_write && (reg_addr_i == `ADDR_IN_ENDPOINT_CONTROL_HIGH) &&
          (idx_ep != 2'h0))
      begin
        split_q[idx_ep] <= reg_wdata_i[`BIT_SPLIT]; // [RULE11]
        direction_select_q[idx_ep] <=
          reg_wdata_i[`BIT_DIRECTION_SELECT]; // [RULE13]
        double_in_q[idx_ep] <= reg_wdata_i[`BIT_DOUBLE_IN]; // [RULE14]
        double_out_q[idx_ep] <= reg_wdata_i[`BIT_DOUBLE_OUT]; // [RULE15]
      end
    end
  end

  // --------------------------------------------------------------------
  // Logical FIFOs: index 2*ep+0 is the lower (OUT or whole) half,
  // 2*ep+1 the upper (IN) half used only in split mode
  // --------------------------------------------------------------------
  wire [9:0] fbase [0:7];
  wire [10:0] fsize [0:7];
  wire [9:0] fwp [0:7];
  wire [9:0] frp [0:7];
  wire [10:0] fcnt [0:7];
  wire [7:0] fpush;
  wire [7:0] fpop;
  wire [2:0] cpu_wf;
  wire [2:0] cpu_rf;
  wire [2:0] usb_wf;
  wire [2:0] usb_rf;
  wire cpu_w_dir_ok;
  wire cpu_r_dir_ok;
  wire usb_w_dir_ok;
  wire usb_r_dir_ok;
  wire cpu_push_ok;
  wire cpu_pop_ok;
  wire usb_push_ok;
  wire usb_pop_ok;

  // Port writes feed the IN half, port reads drain the OUT half
  assign cpu_wf = {port_ep, split_q[port_ep]}; // [RULE18]
  assign cpu_rf = {port_ep, 1'b0}; // [RULE18]
  assign usb_wf = {usb_ep_i, 1'b0};
  assign usb_rf = {usb_ep_i, split_q[usb_ep_i]};

  // Unsplit FIFOs of endpoints 1 to 3 run one way only, as direction select says (1 = IN)
  assign cpu_w_dir_ok = split_q[port_ep] || direction_select_q[port_ep] ||
                        (port_ep == 2'h0); // [RULE13]
  assign cpu_r_dir_ok = split_q[port_ep] || !direction_select_q[port_ep] ||
                        (port_ep == 2'h0); // [RULE13]
  assign usb_w_dir_ok = split_q[usb_ep_i] || !direction_select_q[usb_ep_i] ||
                        (usb_ep_i == 2'h0);
  assign usb_r_dir_ok = split_q[usb_ep_i] || direction_select_q[usb_ep_i] ||
                        (usb_ep_i == 2'h0);

  // Full writes and empty reads are dropped rather than corrupting data
  assign cpu_push_ok = reg_wr_i && fifo_port_hit && cpu_w_dir_ok &&
                       (fcnt[cpu_wf] < fsize[cpu_wf]); // [RULE17]
  assign cpu_pop_ok = reg_rd_i && fifo_port_hit && cpu_r_dir_ok &&
                      (fcnt[cpu_rf] != 11'h000); // [RULE17]
  assign usb_push_ok = usb_push_i && usb_w_dir_ok && !(cpu_push_ok &&
                       (cpu_wf == usb_wf)) && (fcnt[usb_wf] < fsize[usb_wf]);
  assign usb_pop_ok = usb_pop_i && usb_r_dir_ok && !(cpu_pop_ok &&
                      (cpu_rf == usb_rf)) && (fcnt[usb_rf] != 11'h000);

  genvar f;
  generate
    for (f = 0; f < 8; f = f + 1)
    begin : g_fifo
      wire [10:0] ep_size;
      wire [9:0] ep_base;
      wire is_split;

      assign ep_size = (f / 2 == 0) ? `EP0_SIZE :
                       (f / 2 == 1) ? `EP1_SIZE :
                       (f / 2 == 2) ? `EP2_SIZE : `EP3_SIZE; // [RULE10]
      assign ep_base = (f / 2 == 0) ? `EP0_BASE :
                       (f / 2 == 1) ? `EP1_BASE :
                       (f / 2 == 2) ? `EP2_BASE : `EP3_BASE;
      assign is_split = split_q[f / 2];
      // Upper half goes to IN when split, lower half to OUT
      assign fsize[f] = (f % 2 == 1) ?
                        (is_split ? {1'b0, ep_size[10:1]} : 11'h000) :
                        (is_split ? {1'b0, ep_size[10:1]} : ep_size); // [RULE12]
      assign fbase[f] = (f % 2 == 1) ? ep_base + ep_size[10:1] :
                        ep_base; // [RULE12]
      assign fpush[f] = (cpu_push_ok && (cpu_wf == f)) ||
                        (usb_push_ok && (usb_wf == f));
      assign fpop[f] = (cpu_pop_ok && (cpu_rf == f)) ||
                       (usb_pop_ok && (usb_rf == f));

      endpoint_fifo_ptr u_ptr
      (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .size_i(fsize[f]),
        .push_i(fpush[f]),
        .pop_i(fpop[f]),
        .wr_ptr_o(fwp[f]),
        .rd_ptr_o(frp[f]),
        .count_o(fcnt[f])
      );
    end
  endgenerate

  // --------------------------------------------------------------------
  // FIFO memory
  // --------------------------------------------------------------------
  wire [9:0] cpu_waddr;
  wire [9:0] cpu_raddr;
  wire [9:0] usb_waddr;
  wire [9:0] usb_raddr;
  assign cpu_waddr = fbase[cpu_wf] + fwp[cpu_wf];
  assign cpu_raddr = fbase[cpu_rf] + frp[cpu_rf];
  assign usb_waddr = fbase[usb_wf] + fwp[usb_wf];
  assign usb_raddr = fbase[usb_rf] + frp[usb_rf];

  // Two writers never share a logical FIFO in one cycle, so no clash
  always @(posedge clk_i)
  begin
    if (cpu_push_ok)
      mem[cpu_waddr] <= reg_wdata_i; // [RULE17]
    if (usb_push_ok)
      mem[usb_waddr] <= usb_push_data_i;
  end

  // --------------------------------------------------------------------
  // Register reads and USB-side data
  // --------------------------------------------------------------------
  reg [7:0] rdata_d;
  always @*
  begin
    rdata_d = 8'h00;
    if (reg_addr_i == `ADDR_ENDPOINT_INDEX_SELECT)
      rdata_d = {4'h0, endpoint_select_q}; // [RULE2]
    else if (reg_addr_i == `ADDR_CLOCK_RECOVERY_CONTROL)
      rdata_d = clock_recovery_q;
    else if ((reg_addr_i == `ADDR_IN_ENDPOINT_CONTROL_HIGH) &&
             index_valid) // [RULE21]
    begin
      rdata_d[`BIT_DOUBLE_IN] = double_in_q[idx_ep];
      rdata_d[`BIT_DOUBLE_OUT] = double_out_q[idx_ep];
      rdata_d[`BIT_DIRECTION_SELECT] = direction_select_q[idx_ep];
      rdata_d[`BIT_SPLIT] = split_q[idx_ep];
    end
    else if (cpu_pop_ok)
      rdata_d = mem[cpu_raddr]; // [RULE17]
  end

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      reg_rdata_o <= 8'h00;
      usb_pop_data_o <= 8'h00;
    end
    else
    begin
      if (reg_rd_i)
        reg_rdata_o <= rdata_d;
      if (usb_pop_ok)
        usb_pop_data_o <= mem[usb_raddr];
    end
  end

  // --------------------------------------------------------------------
  // Maximum packet sizes for the indexed endpoint
  // --------------------------------------------------------------------
  reg [10:0] full_size;
  reg [10:0] in_size_d;
  reg [10:0] out_size_d;
  always @*
  begin
    full_size = (idx_ep == 2'h0) ? `EP0_SIZE :
                (idx_ep == 2'h1) ? `EP1_SIZE :
                (idx_ep == 2'h2) ? `EP2_SIZE : `EP3_SIZE; // [RULE16]
    in_size_d = split_q[idx_ep] ? {1'b0, full_size[10:1]} : full_size;
    out_size_d = in_size_d;
    // Double buffering splits the region into two packet slots
    if (double_in_q[idx_ep])
      in_size_d = {1'b0, in_size_d[10:1]}; // [RULE14]
    if (split_q[idx_ep] ? double_out_q[idx_ep] : double_in_q[idx_ep])
      out_size_d = {1'b0, out_size_d[10:1]}; // [RULE15]
    if (!index_valid)
    begin
      in_size_d = 11'h000;
      out_size_d = 11'h000;
    end
  end

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      max_in_packet_o <= 10'h000;
      max_out_packet_o <= 10'h000;
    end
    else
    begin
      max_in_packet_o <= in_size_d[9:0]; // [RULE16]
      max_out_packet_o <= out_size_d[9:0]; // [RULE16]
    end
  end

  // --------------------------------------------------------------------
  // Clock recovery
  // --------------------------------------------------------------------
  // clk_i is taken to derive from the trimmed oscillator, so a long frame
  // in clk_i cycles means the oscillator runs fast.
  localparam [31:0] FRAME_WORD = FRAME_CYCLES;
  localparam [20:0] FRAME_LEN = FRAME_WORD[20:0];
  localparam [20:0] ERR_LIMIT = FRAME_WORD[23:3];
  localparam [20:0] COARSE_ERR = FRAME_WORD[30:10];

  reg [20:0] frame_cnt_q;
  reg seen_q;
  reg [20:0] err_mag;
  reg err_fast;
  reg [6:0] step;
  wire rec_en;
  wire frame_evt;

  assign rec_en = clock_recovery_q[`BIT_RECOVERY_ENABLE]; // [RULE7]
  // Low speed has no frame token, only keep-alive markers
  assign frame_evt = clock_recovery_q[`BIT_LOW_SPEED_RECOVERY] ?
                     keepalive_i : sof_i; // [RULE9]

  always @*
  begin
    err_fast = (frame_cnt_q > FRAME_LEN);
    err_mag = err_fast ? frame_cnt_q - FRAME_LEN : FRAME_LEN - frame_cnt_q;
    if (clock_recovery_q[`BIT_RECOVERY_SINGLE_STEP])
      step = 7'h01; // [RULE8]
    else
      step = (err_mag >= COARSE_ERR) ? `COARSE_STEP : 7'h01;
  end

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      frame_cnt_q <= 21'h000000;
      seen_q <= 1'b0;
      osc_trim_o <= `TRIM_RESET;
    end
    else if (!rec_en)
    begin
      frame_cnt_q <= 21'h000000;
      seen_q <= 1'b0;
    end
    else if (frame_evt)
    begin
      frame_cnt_q <= 21'h000001;
      seen_q <= 1'b1;
      // Wild intervals mean a lost frame, not a clock error
      if (seen_q && (err_mag != 21'h000000) && (err_mag < ERR_LIMIT))
      begin
        if (err_fast)
          osc_trim_o <= (osc_trim_o > step) ? osc_trim_o - step
                                            : 7'h00; // [RULE5]
        else
          osc_trim_o <= (osc_trim_o < 7'h7f - step) ? osc_trim_o + step
                                                    : 7'h7f; // [RULE5]
      end
    end
    else if (frame_cnt_q != 21'h1fffff)
      frame_cnt_q <= frame_cnt_q + 21'h000001;
  end

endmodule // usb_endpoint_fifo_and_clock_recovery

`default_nettype wire

/* tb/usb_ep_checker.sv */
// Port-level assertions for the endpoint index, recovery and FIFO block.
// Assumes one clock and sync reset; bound to every instance of the top.
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep_defines.vh"
module usb_ep_checker
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [9:0] max_in_packet_o,
  input wire logic [9:0] max_out_packet_o,
  input wire logic sof_i,
  input wire logic keepalive_i,
  input wire logic [6:0] osc_trim_o
);
  logic [3:0] idx_q;
  logic [7:0] ctl_q;
  wire mark = ctl_q[5] ? keepalive_i : sof_i;
  wire rd_idx = reg_rd_i && reg_addr_i == `ADDR_ENDPOINT_INDEX_SELECT;
  wire rd_ctl = reg_rd_i && reg_addr_i == `ADDR_CLOCK_RECOVERY_CONTROL;
  wire rd_cfg = reg_rd_i && reg_addr_i == `ADDR_IN_ENDPOINT_CONTROL_HIGH;
  // Shadow copies so expectations never lean on the design's state
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      idx_q <= `ENDPOINT_INDEX_RESET;
      ctl_q <= `CLOCK_RECOVERY_RESET;
    end
    else if (reg_wr_i && reg_addr_i == `ADDR_ENDPOINT_INDEX_SELECT)
      idx_q <= reg_wdata_i[3:0];
    else if (reg_wr_i && reg_addr_i == `ADDR_CLOCK_RECOVERY_CONTROL)
      ctl_q <= reg_wdata_i;
  end
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_idx_zero; !srst_i && idx_q == 4'h0 ##1 idx_q == 4'h0;
  endsequence
  sequence s_idx_rsv; idx_q > 4'h3 ##1 idx_q > 4'h3; endsequence
  property p_idx_rd; rd_idx |=> reg_rdata_o == {4'h0, $past(idx_q)};
  endproperty
  property p_ctl_rd; rd_ctl |=> reg_rdata_o[7:5] == $past(ctl_q[7:5]);
  endproperty
  property p_unmap; reg_rd_i && reg_addr_i > `ADDR_FIFO_PORT_LAST
    |=> reg_rdata_o == 8'h00; endproperty
  property p_rsv_rd; rd_cfg && idx_q > 4'h3 |=> reg_rdata_o == 8'h00;
  endproperty
  property p_rsv_max; s_idx_rsv |-> max_in_packet_o == 10'h000
    && max_out_packet_o == 10'h000; endproperty
  property p_ep0_max; s_idx_zero |-> max_in_packet_o == 10'h040
    && max_out_packet_o == 10'h040; endproperty
  property p_no_mark; !mark |=> $stable(osc_trim_o); endproperty
  property p_off; !ctl_q[7] |=> $stable(osc_trim_o); endproperty
  property p_single; ctl_q[6] |=> osc_trim_o == $past(osc_trim_o)
    || osc_trim_o + 7'h01 == $past(osc_trim_o)
    || osc_trim_o == $past(osc_trim_o) + 7'h01; endproperty
  property p_rd_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
  a_idx_rd: assert property (p_idx_rd) else $error("index read");
  a_ctl_rd: assert property (p_ctl_rd) else $error("ctrl read");
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  a_rsv_rd: assert property (p_rsv_rd) else $error("rsv read");
  a_rsv_max: assert property (p_rsv_max) else $error("rsv max");
  a_ep0_max: assert property (p_ep0_max) else $error("ep0 max");
  a_no_mark: assert property (p_no_mark) else $error("trim moved");
  a_off: assert property (p_off) else $error("trim while off");
  a_single: assert property (p_single) else $error("big step");
  a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
endmodule // usb_ep_checker
bind usb_endpoint_fifo_and_clock_recovery usb_ep_checker u_usb_ep_checker
(
  .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .max_in_packet_o(max_in_packet_o),
  .max_out_packet_o(max_out_packet_o), .sof_i(sof_i),
  .keepalive_i(keepalive_i), .osc_trim_o(osc_trim_o)
);
`default_nettype wire

/* tb/usb_marker_host.sv */
// Host-side model that sends frame or keep-alive markers at a set period.
// Assumes the bench starts and stops it; idle between markers.
`timescale 1ns/1ps
`default_nettype none
module usb_marker_host
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic run_i,
  input wire logic low_i,
  input wire logic [15:0] gap_i,
  output logic sof_o,
  output logic keepalive_o
);
  logic [15:0] cnt_q;
  // Period is read at each reload, so a new gap lands one marker late
  always @(posedge clk_i)
  begin
    sof_o <= 1'b0;
    keepalive_o <= 1'b0;
    if (srst_i || !run_i)
      cnt_q <= gap_i;
    else if (cnt_q == 16'h0001)
    begin
      cnt_q <= gap_i;
      sof_o <= !low_i;
      keepalive_o <= low_i;
    end
    else
      cnt_q <= cnt_q - 16'h0001;
  end
endmodule // usb_marker_host
`default_nettype wire

/* tb/usb_endpoint_fifo_and_clock_recovery_tb.sv */
// Self-checking bench for the endpoint index, recovery and FIFO block.
// Drives register port and USB side; markers come from the host model.
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep_defines.vh"
module usb_endpoint_fifo_and_clock_recovery_tb;
  localparam int F = 2048;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [5:0] addr = 6'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [1:0] ep = 2'h0;
  logic push = 1'b0;
  logic pop = 1'b0;
  logic [7:0] pdata = 8'h00;
  logic run = 1'b0;
  logic low = 1'b0;
  logic [15:0] gap = 16'h0800;
  wire [7:0] rdata;
  wire [7:0] popdata;
  wire [9:0] max_in;
  wire [9:0] max_out;
  wire sof;
  wire kal;
  wire [6:0] trim;
  int n_fail = 0;
  int num_checks = 0;
  always #2 clk_i = ~clk_i;
  usb_endpoint_fifo_and_clock_recovery #(.FRAME_CYCLES(F))
    u_usb_endpoint_fifo_and_clock_recovery
  (
    .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .usb_ep_i(ep), .usb_push_i(push), .usb_push_data_i(pdata),
    .usb_pop_i(pop), .usb_pop_data_o(popdata), .max_in_packet_o(max_in),
    .max_out_packet_o(max_out), .sof_i(sof), .keepalive_i(kal),
    .osc_trim_o(trim)
  );
  usb_marker_host u_usb_marker_host
  (
    .clk_i(clk_i), .srst_i(srst_i), .run_i(run), .low_i(low),
    .gap_i(gap), .sof_o(sof), .keepalive_o(kal)
  );
  task automatic results;
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic upush(input logic [1:0] e, input logic [7:0] d);
    @(posedge clk_i);
    ep <= e;
    pdata <= d;
    push <= 1'b1;
    @(posedge clk_i);
    push <= 1'b0;
  endtask
  task automatic popc(input logic [1:0] e, input logic [7:0] x);
    @(posedge clk_i);
    ep <= e;
    pop <= 1'b1;
    @(posedge clk_i);
    pop <= 1'b0;
    #1;
    chk(popdata, x);
  endtask
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_regs;
    rdc(`ADDR_ENDPOINT_INDEX_SELECT, 8'h00);
    rdc(`ADDR_CLOCK_RECOVERY_CONTROL, 8'h09);
    chk(max_in, 10'h040);
    wreg(`ADDR_ENDPOINT_INDEX_SELECT, 8'hf2);
    rdc(`ADDR_ENDPOINT_INDEX_SELECT, 8'h02);
    wreg(`ADDR_ENDPOINT_INDEX_SELECT, 8'h05);
    wreg(`ADDR_IN_ENDPOINT_CONTROL_HIGH, 8'h04);
    rdc(`ADDR_IN_ENDPOINT_CONTROL_HIGH, 8'h00);
    chk(max_in, 10'h000);
    wreg(`ADDR_ENDPOINT_INDEX_SELECT, 8'h02);
    rdc(`ADDR_IN_ENDPOINT_CONTROL_HIGH, 8'h00);
    rdc(6'h30, 8'h00);
  endtask
  task automatic t_split;
    wreg(`ADDR_IN_ENDPOINT_CONTROL_HIGH, 8'h04);
    wreg(6'h22, 8'haa);
    rdc(6'h22, 8'h00);
    popc(2'h2, 8'haa);
    upush(2'h2, 8'h5a);
    rdc(6'h22, 8'h5a);
    wreg(`ADDR_IN_ENDPOINT_CONTROL_HIGH, 8'h00);
  endtask
  task automatic t_unsplit;
    wreg(`ADDR_ENDPOINT_INDEX_SELECT, 8'h01);
    upush(2'h1, 8'h55);
    upush(2'h1, 8'h66);
    rdc(6'h21, 8'h55);
    rdc(6'h21, 8'h66);
    rdc(6'h21, 8'h00);
    wreg(`ADDR_IN_ENDPOINT_CONTROL_HIGH, 8'h08);
    upush(2'h1, 8'h11);
    wreg(6'h21, 8'h77);
    popc(2'h1, 8'h77);
    wreg(`ADDR_IN_ENDPOINT_CONTROL_HIGH, 8'h00);
  endtask
  task automatic t_max;
    logic [7:0] cfg [4];
    int si [4];
    int so [4];
    cfg = '{8'h00, 8'h04, 8'h44, 8'h80};
    si = '{0, 1, 1, 1};
    so = '{0, 1, 2, 1};
    wreg(`ADDR_ENDPOINT_INDEX_SELECT, 8'h00);
    wreg(`ADDR_IN_ENDPOINT_CONTROL_HIGH, 8'h84);
    repeat (2) @(posedge clk_i);
    #1;
    chk(max_in, 10'h040);
    for (int e = 1; e < 4; e++)
    begin
      wreg(`ADDR_ENDPOINT_INDEX_SELECT, e[7:0]);
      for (int i = 0; i < 4; i++)
      begin
        wreg(`ADDR_IN_ENDPOINT_CONTROL_HIGH, cfg[i]);
        repeat (2) @(posedge clk_i);
        #1;
        chk(max_in, 10'h020 << (e + 1 - si[i]));
        chk(max_out, 10'h020 << (e + 1 - so[i]));
      end
      wreg(`ADDR_IN_ENDPOINT_CONTROL_HIGH, 8'h00);
    end
  endtask
  // Two markers per phase: the first only re-arms after the long pause
  task automatic phase(input logic [7:0] c, input logic l, input int g,
    input logic [6:0] x);
    int k;
    wreg(`ADDR_CLOCK_RECOVERY_CONTROL, c);
    @(posedge clk_i);
    low <= l;
    gap <= g[15:0];
    run <= 1'b1;
    k = 0;
    repeat (3 * F)
    begin
      @(posedge clk_i);
      #1;
      if (sof || kal)
        k++;
      if (k == 2)
        break;
    end
    if (k != 2)
    begin
      n_fail++;
      $display("ERROR %0t no marker", $time);
      results();
    end
    repeat (3) @(posedge clk_i);
    #1;
    chk(trim, x);
    run <= 1'b0;
    repeat (600) @(posedge clk_i);
  endtask
  task automatic t_recovery;
    phase(8'h89, 1'b0, F + 100, 7'h3c);
    phase(8'h89, 1'b0, F - 100, 7'h40);
    phase(8'hc9, 1'b0, F + 100, 7'h3f);
    phase(8'ha9, 1'b0, F + 100, 7'h3f);
    phase(8'ha9, 1'b1, F - 100, 7'h43);
    phase(8'h09, 1'b0, F + 100, 7'h43);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    t_regs();
    t_split();
    t_unsplit();
    t_max();
    t_recovery();
    results();
  end
endmodule // usb_endpoint_fifo_and_clock_recovery_tb
`default_nettype wire
